// ---- ccp_mode_control_pwm.sv ----
// Capture/compare/PWM block with APB register access
`timescale 1ns/1ps
`include "ccp_cfg.svh"

module ccp_mode_control_pwm
(
	input  wire logic                  i_clk,
	input  wire logic                  i_resetn,
	input  wire ccp_pkg::ccp_apb_req_s i_apb,
	output ccp_pkg::ccp_apb_rsp_s      o_apb,
	input  wire logic                  i_module_io_pin,
	output logic                       o_module_io_pin,
	output logic                       o_module_io_pin_oe,
	output logic                       o_adc_start
);
	import ccp_pkg::*;

	ccp_state_s state_reg;
	ccp_state_s state_next;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] zext8(input logic [7:0] v);
		zext8 = {24'h000000, v};
	endfunction

	function automatic logic [31:0] zext16(input logic [15:0] v);
		zext16 = {16'h0000, v};
	endfunction

	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = (m[3:2] == 2'b11);
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb
	begin
		logic [3:0]  mode;
		logic        wr;
		logic        rd;
		logic        rise;
		logic        fall;
		logic        cmp_hit;
		logic        cap_hit;
		logic        cap_on;
		logic        cmp_on;
		logic [9:0]  duty_now;
		logic [9:0]  duty_buf;
		logic [9:0]  time_base;
		logic [9:0]  tb_inc;
		logic        period_end;
		logic [31:0] rdata;
		mode       = state_reg.mode_control_register[`CCP_MODE_MSB:`CCP_MODE_LSB];
		wr         = 1'b0;
		rd         = 1'b0;
		rise       = 1'b0;
		fall       = 1'b0;
		cmp_hit    = 1'b0;
		cap_hit    = 1'b0;
		cap_on     = 1'b0;
		cmp_on     = 1'b0;
		duty_now   = 10'h000;
		duty_buf   = 10'h000;
		time_base  = 10'h000;
		tb_inc     = 10'h000;
		period_end = 1'b0;
		rdata      = 32'h00000000;
		state_next = state_reg;

		// ------------------------------------------------------------------
		// Pin input
		// ------------------------------------------------------------------
		// Pin input: three stages, a change counts when stages 2 and 3 agree
		state_next.in_sync = {state_reg.in_sync[1:0], i_module_io_pin};
		if (state_reg.in_sync[2] == state_reg.in_sync[1])
		begin
			state_next.in_stable = state_reg.in_sync[2];
			rise = state_reg.in_sync[2] & ~state_reg.in_stable;
			fall = ~state_reg.in_sync[2] & state_reg.in_stable;
		end

		// Free-running 16-bit timer used for capture and compare
		state_next.free_timer = state_reg.free_timer + 16'h0001;
		state_next.pin.adc_start = 1'b0;

		// ------------------------------------------------------------------
		// Mode decode
		// ------------------------------------------------------------------
		cap_on = (mode[3:2] == 2'b01);
		cmp_on = (mode[3:2] == 2'b10) || (mode == CCP_M_TOGGLE);
		cmp_hit = cmp_on && (state_reg.free_timer == state_reg.compare_value);

		// ------------------------------------------------------------------
		// PWM time base
		// ------------------------------------------------------------------
		// 10-bit time base runs at the system clock rate, so PWM frequency
		// scales with the clock directly
		duty_now  = {state_reg.duty_upper_register,
			state_reg.mode_control_register[`CCP_DLOW_MSB:`CCP_DLOW_LSB]};
		duty_buf  = {state_reg.duty_buffer_register, state_reg.duty_low_latch};
		time_base = {state_reg.period_timer_count, state_reg.sub_count};
		// Match one step ahead: the pin is a register, so it reads low
		// in the very cycle in which the time base equals the duty
		tb_inc    = time_base + 10'h001;
		period_end = (state_reg.period_timer_count
			== state_reg.period_limit_register) && (state_reg.sub_count == 2'b11);

		if (is_pwm(mode))
		begin
			state_next.pin.pin_oe = 1'b1;
			state_next.sub_count  = state_reg.sub_count + 2'b01;
			if (period_end)
			begin
				// Period rollover reloads the double buffer
				state_next.period_timer_count   = 8'h00;
				state_next.duty_buffer_register = duty_now[9:2];
				state_next.duty_low_latch       = duty_now[1:0];
				state_next.out_latch            = (duty_now != 10'h000);
			end
			else
			begin
				if (state_reg.sub_count == 2'b11)
					state_next.period_timer_count = state_reg.period_timer_count + 8'h01;
				if (tb_inc == duty_buf)
					state_next.out_latch = 1'b0;
			end
		end
		else if (cap_on || cmp_on)
		begin
			state_next.pin.pin_oe = cmp_on && (mode != CCP_M_CMP_SWI);
			state_next.sub_count = 2'b00;
			state_next.period_timer_count = 8'h00;
			case (mode)
				CCP_M_CAP_FALL: cap_hit = fall;
				CCP_M_CAP_R1:   cap_hit = rise;
				CCP_M_CAP_R4:
				begin
					if (rise)
						state_next.presc_count = state_reg.presc_count + 4'h1;
					cap_hit = rise
						&& ((state_reg.presc_count & 4'h3) == `CCP_PRESC_4);
				end
				CCP_M_CAP_R16:
				begin
					if (rise)
						state_next.presc_count = state_reg.presc_count + 4'h1;
					cap_hit = rise && (state_reg.presc_count == `CCP_PRESC_16);
				end
				CCP_M_CMP_SET:
					if (cmp_hit) state_next.out_latch = 1'b1;
				CCP_M_CMP_CLR:
					if (cmp_hit) state_next.out_latch = 1'b0;
				CCP_M_TOGGLE:
					if (cmp_hit) state_next.out_latch = ~state_reg.out_latch;
				CCP_M_CMP_ADC:
					if (cmp_hit && state_reg.adc_enable)
						state_next.pin.adc_start = 1'b1;
				default: ; // CCP_M_CMP_SWI only flags
			endcase
			if (cap_hit)
			begin
				state_next.capture_value     = state_reg.free_timer;
				state_next.module_event_flag = 1'b1;
			end
			if (cmp_hit && (mode != CCP_M_TOGGLE))
				state_next.module_event_flag = 1'b1;
		end
		else
		begin
			// Off and reserved codes release the pin and clear the output latch, prescaler and time base
			state_next.pin.pin_oe         = 1'b0;
			state_next.out_latch          = 1'b0;
			state_next.presc_count        = 4'h0;
			state_next.sub_count          = 2'b00;
			state_next.period_timer_count = 8'h00;
		end
		if (mode == CCP_M_TOGGLE && cmp_hit)
			state_next.module_event_flag = 1'b1;
		state_next.pin.pin_out = state_next.out_latch;

		// ------------------------------------------------------------------
		// APB slave: zero-wait, answers in the access cycle
		// ------------------------------------------------------------------
		wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
		rd = i_apb.psel && !i_apb.pwrite;
		state_next.rsp.pready  = i_apb.psel && !i_apb.penable;
		state_next.rsp.pslverr = 1'b0;
		case (i_apb.paddr)
			`CCP_OFF_MODE:     rdata = zext8(state_reg.mode_control_register);
			`CCP_OFF_DUTY_UP:  rdata = zext8(state_reg.duty_upper_register);
			`CCP_OFF_DUTY_BUF: rdata = zext8(state_reg.duty_buffer_register);
			`CCP_OFF_PERIOD:   rdata = zext8(state_reg.period_limit_register);
			`CCP_OFF_TIMER:    rdata = zext8(state_reg.period_timer_count);
			`CCP_OFF_CAPTURE:  rdata = zext16(state_reg.capture_value);
			`CCP_OFF_COMPARE:  rdata = zext16(state_reg.compare_value);
			`CCP_OFF_STATUS:   rdata = {31'h00000000, state_reg.module_event_flag};
			`CCP_OFF_ADC_EN:   rdata = {31'h00000000, state_reg.adc_enable};
			default:
			begin
				rdata = 32'h00000000;
				state_next.rsp.pslverr = i_apb.psel && !i_apb.penable;
			end
		endcase
		if (rd && !i_apb.penable)
			state_next.rsp.prdata = rdata;
		else if (!i_apb.psel)
			state_next.rsp.prdata = 32'h00000000;

		// ------------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------------
		// Writes happen in the access cycle, when pready stands high
		if (wr && state_reg.rsp.pready)
		begin
			case (i_apb.paddr)
				`CCP_OFF_MODE:
					state_next.mode_control_register =
						i_apb.pwdata[7:0] & `CCP_CTRL_WMASK;
				`CCP_OFF_DUTY_UP:
					state_next.duty_upper_register = i_apb.pwdata[7:0];
				`CCP_OFF_DUTY_BUF:
					// Buffer is read-only while PWM runs
					if (!is_pwm(mode))
						state_next.duty_buffer_register = i_apb.pwdata[7:0];
				`CCP_OFF_PERIOD:
					state_next.period_limit_register = i_apb.pwdata[7:0];
				`CCP_OFF_TIMER:
					state_next.period_timer_count = i_apb.pwdata[7:0];
				`CCP_OFF_CAPTURE:
					state_next.capture_value = i_apb.pwdata[15:0];
				`CCP_OFF_COMPARE:
					state_next.compare_value = i_apb.pwdata[15:0];
				`CCP_OFF_STATUS:
					// A hardware set in the same cycle wins over the clear
					if (i_apb.pwdata[0] && !(cmp_hit || cap_hit))
						state_next.module_event_flag = 1'b0;
				`CCP_OFF_ADC_EN:
					state_next.adc_enable = i_apb.pwdata[0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			// Everything to defaults, pin undriven
			state_reg <= '{
				mode_control_register: `CCP_RST_CTRL,
				duty_upper_register:   `CCP_RST_BYTE,
				duty_buffer_register:  `CCP_RST_BYTE,
				duty_low_latch:        2'b00,
				period_limit_register: `CCP_RST_PERIOD,
				period_timer_count:    `CCP_RST_BYTE,
				sub_count:             2'b00,
				free_timer:            `CCP_RST_WORD16,
				capture_value:         `CCP_RST_WORD16,
				compare_value:         `CCP_RST_WORD16,
				module_event_flag:     1'b0,
				adc_enable:            1'b0,
				out_latch:             1'b0,
				presc_count:           4'h0,
				in_sync:               3'b000,
				in_stable:             1'b0,
				rsp:                   '{1'b0, 32'h00000000, 1'b0},
				pin:                   '{1'b0, 1'b0, 1'b0}
			};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign o_apb              = state_reg.rsp;
	assign o_module_io_pin    = state_reg.pin.pin_out;
	assign o_module_io_pin_oe = state_reg.pin.pin_oe;
	assign o_adc_start        = state_reg.pin.adc_start;

endmodule // ccp_mode_control_pwm

// ---- ccp_cfg.svh ----
// Register offsets, field positions, reset values and counts for the CCP block
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

`define CCP_OFF_MODE       12'h000
`define CCP_OFF_DUTY_UP    12'h004
`define CCP_OFF_DUTY_BUF   12'h008
`define CCP_OFF_PERIOD     12'h00c
`define CCP_OFF_TIMER      12'h010
`define CCP_OFF_CAPTURE    12'h014
`define CCP_OFF_COMPARE    12'h018
`define CCP_OFF_STATUS     12'h01c
`define CCP_OFF_ADC_EN     12'h020

`define CCP_MODE_LSB       0
`define CCP_MODE_MSB       3
`define CCP_DLOW_LSB       4
`define CCP_DLOW_MSB       5
`define CCP_CTRL_WMASK     8'h3f

`define CCP_RST_CTRL       8'h00
`define CCP_RST_BYTE       8'h00
`define CCP_RST_PERIOD     8'hff
`define CCP_RST_WORD16     16'h0000

`define CCP_PRESC_4        4'h3
`define CCP_PRESC_16       4'hf

`endif

// ---- ccp_pkg.sv ----
// Types shared by the CCP block
package ccp_pkg;

	typedef enum logic [3:0]
	{
		CCP_M_OFF      = 4'b0000,
		CCP_M_RSV1     = 4'b0001,
		CCP_M_TOGGLE   = 4'b0010,
		CCP_M_RSV3     = 4'b0011,
		CCP_M_CAP_FALL = 4'b0100,
		CCP_M_CAP_R1   = 4'b0101,
		CCP_M_CAP_R4   = 4'b0110,
		CCP_M_CAP_R16  = 4'b0111,
		CCP_M_CMP_SET  = 4'b1000,
		CCP_M_CMP_CLR  = 4'b1001,
		CCP_M_CMP_SWI  = 4'b1010,
		CCP_M_CMP_ADC  = 4'b1011
	} ccp_mode_e;

	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ccp_apb_req_s;

	typedef struct packed
	{
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} ccp_apb_rsp_s;

	typedef struct packed
	{
		logic        pin_out;
		logic        pin_oe;
		logic        adc_start;
	} ccp_pin_s;

	typedef struct packed
	{
		logic [7:0]   mode_control_register;
		logic [7:0]   duty_upper_register;
		logic [7:0]   duty_buffer_register;
		logic [1:0]   duty_low_latch;
		logic [7:0]   period_limit_register;
		logic [7:0]   period_timer_count;
		logic [1:0]   sub_count;
		logic [15:0]  free_timer;
		logic [15:0]  capture_value;
		logic [15:0]  compare_value;
		logic         module_event_flag;
		logic         adc_enable;
		logic         out_latch;
		logic [3:0]   presc_count;
		logic [2:0]   in_sync;
		logic         in_stable;
		ccp_apb_rsp_s rsp;
		ccp_pin_s     pin;
	} ccp_state_s;

endpackage

// ---- ccp_mode_control_pwm_asserts.sv ----
// Port checker for the CCP block, bound to its top module
`timescale 1ns/1ps
module ccp_mode_control_pwm_asserts
(
	input  wire logic                  i_clk,
	input  wire logic                  i_resetn,
	input  wire ccp_pkg::ccp_apb_req_s i_apb,
	input  wire ccp_pkg::ccp_apb_rsp_s o_apb,
	input  wire logic                  i_module_io_pin,
	input  wire logic                  o_module_io_pin,
	input  wire logic                  o_module_io_pin_oe,
	input  wire logic                  o_adc_start
);
	import ccp_pkg::*;
	logic [3:0] m_q, m_d1, m_d2;
	wire        acc = o_apb.pready && i_apb.psel && i_apb.penable;
	// Mode must sit still two cycles so registered pin logic has caught up
	wire        st  = (m_q == m_d1) && (m_q == m_d2);
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			m_q  <= 4'h0;
			m_d1 <= 4'h0;
			m_d2 <= 4'h0;
		end
		else
		begin
			if (acc && i_apb.pwrite && i_apb.paddr == 12'h000)
				m_q <= i_apb.pwdata[3:0];
			m_d1 <= m_q;
			m_d2 <= m_d1;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	a_ready_follows: assert property (i_apb.psel && !i_apb.penable
		|=> o_apb.pready) else $error("no ready after setup");
	a_bad_addr_err: assert property (acc && i_apb.paddr > 12'h020
		|-> o_apb.pslverr) else $error("unmapped access not refused");
	a_ctrl_high_zero: assert property (acc && !i_apb.pwrite &&
		i_apb.paddr == 12'h000 |-> o_apb.prdata[31:6] == 26'h0)
		else $error("control upper bits not zero");
	a_off_quiet: assert property (st && m_q inside {4'h0, 4'h1, 4'h3}
		|-> !o_module_io_pin_oe && !o_module_io_pin && !o_adc_start)
		else $error("module active while off");
	a_pwm_drives: assert property (st && m_q[3:2] == 2'b11
		|-> o_module_io_pin_oe) else $error("pwm pin not driven");
	a_cap_input: assert property (st && m_q[3:2] == 2'b01
		|-> !o_module_io_pin_oe) else $error("capture pin driven");
	a_swi_no_pin: assert property (st && m_q == 4'b1010
		|-> !o_module_io_pin_oe) else $error("flag only mode drives pin");
	a_set_no_fall: assert property (st && m_q == 4'b1000
		|-> !$fell(o_module_io_pin)) else $error("set mode lowered pin");
	a_clr_no_rise: assert property (st && m_q == 4'b1001
		|-> !$rose(o_module_io_pin)) else $error("clear mode raised pin");
	a_adc_pulse: assert property (o_adc_start |-> m_q == 4'b1011
		##1 !o_adc_start) else $error("bad conversion trigger");
endmodule // ccp_mode_control_pwm_asserts

bind ccp_mode_control_pwm ccp_mode_control_pwm_asserts u_chk
(
	.i_clk(i_clk), .i_resetn(i_resetn), .i_apb(i_apb), .o_apb(o_apb),
	.i_module_io_pin(i_module_io_pin), .o_module_io_pin(o_module_io_pin),
	.o_module_io_pin_oe(o_module_io_pin_oe), .o_adc_start(o_adc_start)
);

// ---- ccp_pin_model.sv ----
// External source of pulses on the capture input pin
`timescale 1ns/1ps
module ccp_pin_model
(
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_go,
	input  wire logic [7:0] i_edges,
	output logic            o_pin,
	output logic            o_busy
);
	logic [7:0] left;
	logic [3:0] ph;
	assign o_busy = (left != 8'h00);
	// Each pulse is 8 clocks high and 8 low: slow enough for the input
	// synchroniser, and the pin idles low between bursts
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			left  <= 8'h00;
			ph    <= 4'h0;
			o_pin <= 1'b0;
		end
		else if (i_go)
		begin
			left <= i_edges;
			ph   <= 4'h0;
		end
		else if (left != 8'h00)
		begin
			o_pin <= !ph[3];
			ph    <= ph + 4'h1;
			if (ph == 4'hf)
				left <= left - 8'h01;
		end
		else
			o_pin <= 1'b0;
	end
endmodule // ccp_pin_model

// ---- ccp_mode_control_pwm_bench.sv ----
// Self-checking bench for the CCP block
`timescale 1ns/1ps
module ccp_mode_control_pwm_bench;
	import ccp_pkg::*;
	logic         i_clk, i_resetn, go, pin, busy, pin_o, oe, adc, er;
	logic [7:0]   edges;
	logic [31:0]  rd, c0, cyc, adcs;
	ccp_apb_req_s req;
	ccp_apb_rsp_s rsp;
	int           failures, n_compared, hi, i, j, k;
	// Entries: mode, flag expected, pin checked, pin, drive enable
	logic [7:0]   tab [10] = '{8'h8f, 8'h9d, 8'h2f, 8'h04, 8'h8f,
		8'h14, 8'h8f, 8'h34, 8'ha8, 8'hb9};
	ccp_mode_control_pwm uut (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_apb(req), .o_apb(rsp), .i_module_io_pin(pin),
		.o_module_io_pin(pin_o), .o_module_io_pin_oe(oe),
		.o_adc_start(adc));
	ccp_pin_model pm (.i_clk(i_clk), .i_resetn(i_resetn), .i_go(go),
		.i_edges(edges), .o_pin(pin), .o_busy(busy));
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(negedge i_clk)
	begin
		cyc  <= cyc + 32'd1;
		adcs <= adcs + {31'h0, adc === 1'b1};
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task print_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk) req <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_clk) req.penable <= 1'b1;
		// Answer is taken at the rising edge, before that edge's updates
		for (k = 0; k < 20; k++)
		begin
			@(posedge i_clk);
			if (rsp.pready === 1'b1)
				break;
		end
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		if (k == 20)
		begin
			chk("apb_timeout", 1, 0);
			print_verdict();
		end
	endtask
	task pulses(input logic [7:0] n);
		@(posedge i_clk)
		begin
			edges <= n;
			go    <= 1'b1;
		end
		@(posedge i_clk) go <= 1'b0;
		// Model loads its count at that edge; busy is valid from here
		@(negedge i_clk);
		for (j = 0; j < 300 && busy !== 1'b0; j++)
			@(negedge i_clk);
		chk("pulse_done", busy, 0);
		if (busy !== 1'b0)
			print_verdict();
	endtask
	task cmp(input logic [7:0] t);
		apb(1'b1, 12'h018, cyc + 32'd60);
		apb(1'b1, 12'h000, {28'h0, t[7:4]});
		// Poll past the match time, so quiet modes are really tried
		for (i = 0; i < 40; i++)
		begin
			apb(1'b0, 12'h01c, 32'h0);
			if (rd[0] === 1'b1)
				break;
		end
		chk("flag", rd[0], t[3]);
		if (t[2])
			chk("pin", pin_o, t[1]);
		chk("oe", oe, t[0]);
		apb(1'b1, 12'h01c, 32'h1);
	endtask
	task cap(input logic [3:0] m, input logic [7:0] n);
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h000, {28'h0, m});
		apb(1'b0, 12'h014, 32'h0);
		c0 = rd;
		if (n > 8'd1)
			pulses(n - 8'd1);
		apb(1'b0, 12'h014, 32'h0);
		chk("cap_hold", rd, c0);
		pulses(8'd1);
		apb(1'b0, 12'h014, 32'h0);
		chk("cap_new", rd != c0, 1);
	endtask
	task pwm(input logic [7:0] ctl, input logic [7:0] du, input int ex);
		apb(1'b1, 12'h00c, 32'h3);
		apb(1'b1, 12'h004, {24'h0, du});
		apb(1'b1, 12'h000, {24'h0, ctl});
		// The 8-bit timer may need a full wrap before the short period
		repeat (1100) @(posedge i_clk);
		hi = 0;
		repeat (64)
		begin
			@(negedge i_clk);
			hi = hi + (pin_o === 1'b1);
		end
		chk("pwm_high", hi, ex);
		chk("pwm_oe", oe, 1);
		apb(1'b0, 12'h008, 32'h0);
		chk("duty_buf", rd, {24'h0, du});
	endtask
	initial
	begin
		#400000;
		chk("run_timeout", 1, 0);
		print_verdict();
	end
	initial
	begin
		req        = '0;
		go         = 1'b0;
		edges      = 8'h00;
		cyc        = 32'h0;
		adcs       = 32'h0;
		failures   = 0;
		n_compared = 0;
		i_resetn   = 1'b0;
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		chk("oe_rst", oe, 0);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl_rst", rd, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk("period_rst", rd, 32'hff);
		apb(1'b1, 12'h000, 32'hff);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl_mask", rd, 32'h3f);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped_err", {31'h0, er}, 32'h1);
		chk("unmapped_data", rd, 32'h0);
		apb(1'b1, 12'h020, 32'h1);
		for (int t = 0; t < 10; t++)
			cmp(tab[t]);
		chk("adc_starts", adcs, 1);
		cap(4'h7, 8'd16);
		cap(4'h6, 8'd4);
		cap(4'h5, 8'd1);
		cap(4'h4, 8'd1);
		pwm(8'h2c, 8'h01, 24);
		pwm(8'h0f, 8'h00, 0);
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("oe_off", oe, 0);
		print_verdict();
	end
endmodule // ccp_mode_control_pwm_bench
